/* include/pq_pkg.sv */
// constants, types and helpers shared by the transmit queue control block
// assumes a 16-bit indirect host bus and one 40 MHz device clock
package pq_pkg;

    localparam logic [7:0] OFF_TXCTL = 8'h70;
    localparam logic [7:0] OFF_TXFREE = 8'h78;
    localparam logic [7:0] OFF_TXQCMD = 8'h80;
    localparam logic [7:0] OFF_RXQCMD = 8'h82;
    localparam logic [7:0] OFF_TXPTR = 8'h84;
    localparam logic [7:0] OFF_IEN = 8'h90;
    localparam logic [7:0] OFF_IPEND = 8'h92;
    localparam logic [7:0] OFF_SPREQ = 8'h9E;
    localparam logic [7:0] OFF_QDATA = 8'hD0;

    localparam int TXC_FLOW = 3;
    localparam int TXC_PAD = 2;
    localparam int TXC_CRC = 1;
    localparam int TXC_EN = 0;
    localparam int TXC_CS_HI = 8;
    localparam int TXC_CS_LO = 5;
    localparam logic [15:0] TXCTL_MASK = 16'h01EF;
    localparam int TXQC_MANUAL = 0;
    localparam int TXQC_SPACE = 1;
    localparam int TXQC_AUTO = 2;
    localparam int RXQC_DMA = 3;
    localparam int PTR_AUTOINC = 14;
    localparam int IRQ_TXDONE = 14;
    localparam int IRQ_SPACE = 6;
    localparam logic [15:0] PEND_MASK = 16'h4040;
    localparam logic [15:0] REG_RESET = 16'h0000;

    localparam int ADR_HI = 7;
    localparam int ADR_LO = 2;
    localparam int BE_HI = 15;
    localparam int BE_LO = 14;

    localparam int SYNC_W = 21;
    localparam int PIN_CS = 20;
    localparam int PIN_RD = 19;
    localparam int PIN_WR = 18;
    localparam int PIN_CMD = 17;
    localparam int PIN_BIG = 16;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 21'h1C0000;

    localparam logic [13:0] TXQ_BYTES = 14'h1800;
    localparam int RAM_WORDS = 3072;
    localparam int RAM_AW = 12;
    localparam logic [12:0] PTR_STEP = 13'h0002;
    localparam logic [12:0] BC_OFFSET = 13'h0002;
    localparam logic [13:0] HDR_ROUND = 14'h0007;
    localparam logic [10:0] RX_MAX = 11'h7D0;
    localparam logic [7:0] FRAME_ONE = 8'h01;

    typedef enum logic [1:0] {
        PQ_RX_STAT = 2'b00,
        PQ_RX_CNT = 2'b01,
        PQ_RX_DATA = 2'b10
    } pq_rx_e;

    function automatic logic [15:0] pq_swap(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction

    // header plus payload, padded up to a double-word boundary
    function automatic logic [13:0] pq_extent(input logic [10:0] len);
        logic [13:0] s;
        s = {3'h0, len} + HDR_ROUND;
        return {s[13:2], 2'b00};
    endfunction

    function automatic logic [12:0] pq_wrap(input logic [12:0] a,
                                            input logic [13:0] b);
        logic [13:0] s;
        s = {1'b0, a} + b;
        return (s >= TXQ_BYTES) ? 13'(s - TXQ_BYTES) : s[12:0];
    endfunction

endpackage

/* logic/pq_tx_ram.sv */
// transmit packet storage, one write port for the host, one read port
// for the line side; read data appears one clock after the address
`timescale 1ns/10ps
`default_nettype none
module pq_tx_ram
    import pq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [RAM_AW-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [RAM_AW-1:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [RAM_WORDS];

    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // addresses at or above the queue size read as zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rd_data <= REG_RESET;
        end
        else if (32'(rd_addr) < RAM_WORDS)
        begin
            rd_data <= mem[rd_addr];
        end
        else
        begin
            rd_data <= REG_RESET;
        end
    end
endmodule // pq_tx_ram
`default_nettype wire

/* logic/pq_txq_ctrl.sv */
// transmit queue control with host register port and receive framing
// assumes host pins asynchronous to ref_clk, held several clocks each
`timescale 1ns/10ps
`default_nettype none
module pq_txq_ctrl
    import pq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic bus_cmd,
    input wire logic [15:0] sd_in,
    output logic [15:0] sd_out,
    output logic sd_oe,
    input wire logic endian_strap,
    output logic tx_cfg_flow,
    output logic tx_cfg_pad,
    output logic tx_cfg_crc,
    output logic tx_enable,
    output logic [3:0] tx_csum_en,
    output logic tx_frame_pending,
    output logic [12:0] tx_head_addr,
    input wire logic [RAM_AW-1:0] tx_rd_addr,
    output logic [15:0] tx_rd_data,
    input wire logic tx_done,
    input wire logic [10:0] tx_done_bytes,
    input wire logic tx_done_notify,
    input wire logic rx_frame_avail,
    input wire logic [15:0] rx_status,
    input wire logic [11:0] rx_byte_count,
    input wire logic [15:0] rx_word,
    output logic rx_word_take,
    output logic rx_frame_taken,
    output logic irq
);
    logic [SYNC_W-1:0] pin_meta;
    logic [SYNC_W-1:0] pin_s;
    logic rd_prev, wr_prev, rd_act, wr_act, rd_go, wr_go;
    logic cmd_s, big_s;
    logic [15:0] sd_w, host_word, cmd_latch;
    logic [7:0] reg_off;
    logic data_wr, data_rd, buf_wr, buf_rd, reg_wr, dma_on;
    logic [15:0] txctl, rxq_cmd, ien, pend, spreq;
    logic [12:0] tx_ptr, tail, head;
    logic ptr_inc, ptr_auto_q;
    logic [13:0] used, free, enq_ext, done_ext;
    logic [7:0] frames, man_left;
    logic [10:0] frame_len;
    logic manual, auto_enq, space_on;
    logic enq_man, enq_auto, enq_go, win_close, space_hit;
    logic [15:0] pend_set, pend_clr, reg_value, rx_value;
    logic [12:0] wr_byte;
    logic ram_we;
    pq_rx_e rx_state;
    logic [10:0] words_left, rx_len, rx_words;
    logic [11:0] rx_round;

    // all host pins, data included, cross on two flops before use
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_meta <= SYNC_RESET;
            pin_s <= SYNC_RESET;
        end
        else
        begin
            pin_meta <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_cmd,
                         endian_strap, sd_in};
            pin_s <= pin_meta;
        end
    end

    assign cmd_s = pin_s[PIN_CMD];
    assign big_s = pin_s[PIN_BIG];
    assign sd_w = pin_s[15:0];
    assign rd_act = ~pin_s[PIN_CS] & ~pin_s[PIN_RD];
    assign wr_act = ~pin_s[PIN_CS] & ~pin_s[PIN_WR];

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end
        else
        begin
            rd_prev <= rd_act;
            wr_prev <= wr_act;
        end
    end

    // strobes act on their leading edge only
    assign rd_go = rd_act & ~rd_prev;
    assign wr_go = wr_act & ~wr_prev;
    assign data_wr = wr_go & ~cmd_s;
    assign data_rd = rd_go & ~cmd_s;
    assign dma_on = rxq_cmd[RXQC_DMA];
    // upper byte-enable pair selects the high half of the dword
    assign reg_off = {cmd_latch[ADR_HI:ADR_LO],
                      |cmd_latch[BE_HI:BE_LO], 1'b0};
    assign buf_wr = data_wr & dma_on & (reg_off == OFF_QDATA);
    assign buf_rd = data_rd & dma_on & (reg_off == OFF_QDATA);
    assign reg_wr = data_wr & ~buf_wr;
    assign host_word = big_s ? pq_swap(sd_w) : sd_w;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cmd_latch <= REG_RESET;
        end
        else if (wr_go & cmd_s)
        begin
            cmd_latch <= sd_w;
        end
    end

    // plain read/write control registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            txctl <= REG_RESET;
            rxq_cmd <= REG_RESET;
            ien <= REG_RESET;
            spreq <= REG_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_off)
                OFF_TXCTL: txctl <= sd_w & TXCTL_MASK;
                OFF_RXQCMD: rxq_cmd <= sd_w;
                OFF_IEN: ien <= sd_w;
                OFF_SPREQ: spreq <= sd_w;
                default: ;
            endcase
        end
    end

    assign tx_cfg_flow = txctl[TXC_FLOW];
    assign tx_cfg_pad = txctl[TXC_PAD];
    assign tx_cfg_crc = txctl[TXC_CRC];
    assign tx_enable = txctl[TXC_EN];
    assign tx_csum_en = txctl[TXC_CS_HI:TXC_CS_LO];

    // pointer is the byte offset inside the frame being prepared
    assign ptr_inc = buf_wr & ptr_auto_q;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tx_ptr <= '0;
            ptr_auto_q <= 1'b0;
        end
        else if (reg_wr & (reg_off == OFF_TXPTR))
        begin
            tx_ptr <= sd_w[12:0];
            ptr_auto_q <= sd_w[PTR_AUTOINC];
        end
        else if (enq_go)
        begin
            tx_ptr <= '0;
        end
        else if (ptr_inc)
        begin
            tx_ptr <= tx_ptr + PTR_STEP;
        end
    end

    assign wr_byte = pq_wrap(tail, {1'b0, tx_ptr});
    assign ram_we = buf_wr;

    pq_tx_ram u_ram (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(ram_we),
        .wr_addr(wr_byte[12:1]),
        .wr_data(host_word),
        .rd_addr(tx_rd_addr),
        .rd_data(tx_rd_data)
    );

    // enqueue decisions
    assign enq_man = reg_wr & (reg_off == OFF_TXQCMD)
                     & sd_w[TXQC_MANUAL] & ~manual;
    assign win_close = reg_wr & (reg_off == OFF_RXQCMD) & dma_on
                       & ~sd_w[RXQC_DMA];
    assign enq_auto = win_close & auto_enq & (frame_len != '0);
    assign enq_go = enq_man | enq_auto;
    assign enq_ext = pq_extent(frame_len);
    assign done_ext = pq_extent(tx_done_bytes);
    assign free = TXQ_BYTES - used;
    assign space_hit = space_on
                       & ({4'h0, free} >= {spreq, 2'b00});

    // queue occupancy; both header words count against free space
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tail <= '0;
            head <= '0;
            used <= '0;
            frames <= '0;
        end
        else
        begin
            if (enq_go)
            begin
                tail <= pq_wrap(tail, enq_ext);
            end
            if (tx_done)
            begin
                head <= pq_wrap(head, done_ext);
            end
            used <= used + (enq_go ? enq_ext : '0)
                    - (tx_done ? done_ext : '0);
            frames <= frames + {7'h00, enq_go} - {7'h00, tx_done};
        end
    end

    // length is taken from the byte count word of the frame header
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            frame_len <= '0;
        end
        else if (enq_go)
        begin
            frame_len <= '0;
        end
        else if (buf_wr & (tx_ptr == BC_OFFSET))
        begin
            frame_len <= host_word[10:0];
        end
    end

    // command bits: manual, space request, auto mode
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            manual <= 1'b0;
            man_left <= '0;
            auto_enq <= 1'b0;
            space_on <= 1'b0;
        end
        else
        begin
            if (reg_wr & (reg_off == OFF_TXQCMD))
            begin
                auto_enq <= sd_w[TXQC_AUTO];
            end
            if (enq_man)
            begin
                manual <= 1'b1;
                man_left <= frames + FRAME_ONE - {7'h00, tx_done};
            end
            else if (manual & tx_done)
            begin
                man_left <= man_left - FRAME_ONE;
                if (man_left == FRAME_ONE)
                begin
                    manual <= 1'b0;
                end
            end
            if (space_hit)
            begin
                space_on <= 1'b0;
            end
            else if (reg_wr & (reg_off == OFF_TXQCMD) & sd_w[TXQC_SPACE])
            begin
                space_on <= 1'b1;
            end
        end
    end

    assign tx_frame_pending = tx_enable & (frames != '0);
    assign tx_head_addr = head;

    // set wins over a clear landing in the same cycle
    always_comb
    begin
        pend_set = '0;
        pend_set[IRQ_TXDONE] = tx_done & tx_done_notify;
        pend_set[IRQ_SPACE] = space_hit;
        pend_clr = (reg_wr & (reg_off == OFF_IPEND)) ? sd_w : '0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pend <= REG_RESET;
            irq <= 1'b0;
        end
        else
        begin
            pend <= ((pend & ~pend_clr) | pend_set) & PEND_MASK;
            irq <= |(pend & ien);
        end
    end

    always_comb
    begin
        case (reg_off)
            OFF_TXCTL: reg_value = txctl;
            OFF_TXFREE: reg_value = {3'h0, free[12:0]};
            OFF_TXQCMD: reg_value = {13'h0000, auto_enq, space_on, manual};
            OFF_RXQCMD: reg_value = rxq_cmd;
            OFF_TXPTR: reg_value = {1'b0, ptr_auto_q, 1'b0, tx_ptr};
            OFF_IEN: reg_value = ien;
            OFF_IPEND: reg_value = pend;
            OFF_SPREQ: reg_value = spreq;
            default: reg_value = REG_RESET;
        endcase
    end

    // receive frame layout: status, byte count, then data with fcs
    assign rx_len = (rx_byte_count > {1'b0, RX_MAX})
                    ? RX_MAX : rx_byte_count[10:0];
    assign rx_round = {1'b0, rx_len} + 12'h001;
    assign rx_words = rx_round[11:1];

    always_comb
    begin
        case (rx_state)
            PQ_RX_STAT: rx_value = rx_frame_avail
                ? (big_s ? pq_swap(rx_status) : rx_status) : '0;
            PQ_RX_CNT: rx_value = big_s ? pq_swap({4'h0, rx_byte_count})
                : {4'h0, rx_byte_count};
            PQ_RX_DATA: rx_value = rx_word;
            default: rx_value = '0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rx_state <= PQ_RX_STAT;
            words_left <= '0;
            rx_word_take <= 1'b0;
            rx_frame_taken <= 1'b0;
        end
        else
        begin
            rx_word_take <= 1'b0;
            rx_frame_taken <= 1'b0;
            if (buf_rd)
            begin
                case (rx_state)
                    PQ_RX_STAT:
                    begin
                        if (rx_frame_avail)
                        begin
                            rx_state <= PQ_RX_CNT;
                        end
                    end
                    PQ_RX_CNT:
                    begin
                        words_left <= rx_words;
                        if (rx_words == '0)
                        begin
                            rx_state <= PQ_RX_STAT;
                            rx_frame_taken <= 1'b1;
                        end
                        else
                        begin
                            rx_state <= PQ_RX_DATA;
                        end
                    end
                    PQ_RX_DATA:
                    begin
                        rx_word_take <= 1'b1;
                        words_left <= words_left - 11'h001;
                        if (words_left == 11'h001)
                        begin
                            rx_state <= PQ_RX_STAT;
                            rx_frame_taken <= 1'b1;
                        end
                    end
                    default: rx_state <= PQ_RX_STAT;
                endcase
            end
        end
    end

    // read data is held until the next read strobe
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sd_out <= REG_RESET;
        end
        else if (rd_go)
        begin
            sd_out <= cmd_s ? cmd_latch : (buf_rd ? rx_value : reg_value);
        end
    end

    assign sd_oe = rd_act;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_ctl_write;
        reg_wr && reg_off == OFF_TXCTL;
    endsequence

    sequence s_rx_header;
        buf_rd && rx_state == PQ_RX_STAT && rx_frame_avail
        ##1 rx_state == PQ_RX_CNT;
    endsequence

    ctl_enable_a: assert property (s_ctl_write |=>
        tx_enable == $past(sd_w[TXC_EN])
        && tx_cfg_crc == $past(sd_w[TXC_CRC]))
        else $error("transmit enable bits not taken from write");
    csum_bits_a: assert property (s_ctl_write |=>
        tx_csum_en == $past(sd_w[TXC_CS_HI:TXC_CS_LO]))
        else $error("checksum enables not taken from write");
    free_mem_a: assert property (used <= TXQ_BYTES
        && free + used == TXQ_BYTES)
        else $error("free memory accounting broken");
    manual_clear_a: assert property (manual && tx_done
        && man_left == FRAME_ONE |=> !manual)
        else $error("manual enqueue did not clear");
    manual_refuse_a: assert property (reg_wr && reg_off == OFF_TXQCMD
        && manual && !tx_done |=> manual && $stable(tail))
        else $error("pending manual enqueue disturbed");
    space_irq_a: assert property (space_hit |=>
        pend[IRQ_SPACE] && !space_on)
        else $error("space request not answered");
    auto_enq_a: assert property (enq_auto && !tx_done |=>
        frames == $past(frames) + FRAME_ONE)
        else $error("auto enqueue lost a frame");
    window_shut_a: assert property (!dma_on |-> !ram_we)
        else $error("buffer written with window closed");
    ptr_step_a: assert property (buf_wr && ptr_auto_q
        |=> tx_ptr == $past(tx_ptr) + PTR_STEP)
        else $error("pointer did not advance");
    irq_gate_a: assert property (!(|(pend & ien)) |=> !irq)
        else $error("interrupt not gated by enable");
    pend_clear_a: assert property (reg_wr && reg_off == OFF_IPEND
        && sd_w == 16'hFFFF && pend_set == '0 |=> pend == '0)
        else $error("pending flags not cleared");
    // the count read comes one full host access after the status read
    rx_layout_a: assert property (s_rx_header ##[1:40]
        (buf_rd && rx_state == PQ_RX_CNT)
        |=> rx_state != PQ_RX_CNT && words_left <= RX_MAX[10:1])
        else $error("receive header walk broken");
endmodule // pq_txq_ctrl
`default_nettype wire

/* tb/pq_host_model.sv */
// host processor model driving the indirect register bus of the queue block
// assumes the bench owns ref_clk; strobes are slow against the device clock
`timescale 1ns/10ps
`default_nettype none
module pq_host_model
    import pq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [15:0] sd_out,
    output logic bus_cs_n,
    output logic bus_rd_n,
    output logic bus_wr_n,
    output logic bus_cmd,
    output logic [15:0] sd_in
);
    initial
    begin
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        bus_cmd = 1'b0;
        sd_in = 16'h0000;
    end

    // six clocks low, four high: the two-flop synchroniser must see both
    task automatic strobe(input logic cmd, input logic wr,
                          input logic [15:0] d, output logic [15:0] q);
        @(posedge ref_clk);
        #2;
        bus_cs_n = 1'b0;
        bus_cmd = cmd;
        sd_in = wr ? d : ~sd_in;
        bus_wr_n = !wr;
        bus_rd_n = wr;
        repeat (6) @(posedge ref_clk);
        q = sd_out;
        #2;
        bus_cs_n = 1'b1;
        bus_wr_n = 1'b1;
        bus_rd_n = 1'b1;
        // released bus never keeps its last value
        sd_in = ~sd_in;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] off, input logic [15:0] d);
        logic [15:0] q;
        strobe(1'b1, 1'b1, {{2{off[1]}}, 6'h00, off[7:2], 2'b00}, q);
        strobe(1'b0, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] off, output logic [15:0] q);
        strobe(1'b1, 1'b1, {{2{off[1]}}, 6'h00, off[7:2], 2'b00}, q);
        strobe(1'b0, 1'b0, 16'h0000, q);
    endtask

    task automatic frame(input logic [15:0] ctl, input logic [10:0] n);
        wr(OFF_RXQCMD, 16'h0008);
        wr(OFF_TXPTR, 16'h4000);
        wr(OFF_QDATA, ctl);
        wr(OFF_QDATA, {5'h00, n});
        for (int i = 0; i < (n + 1) / 2; i++)
            wr(OFF_QDATA, 16'hA500 + 16'(i));
        wr(OFF_RXQCMD, 16'h0000);
    endtask
endmodule // pq_host_model
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the transmit queue control block
// assumes the host model in pq_host_model and a 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb
    import pq_pkg::*;
;
    logic ref_clk, rst, cs_n, rd_n, wr_n, cmd, sd_oe, strap, flow, pad;
    logic crc, en, pend, tdone, tnote, ravail, take, taken, irq;
    logic [15:0] sd_in, sd_out, rstat, rword, trd, q;
    logic [3:0] csum;
    logic [12:0] head;
    logic [11:0] rcnt, traddr;
    logic [10:0] tbytes;
    int error_cnt, check_count, cyc, takes, taken_cnt, oes;

    pq_txq_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .bus_cs_n(cs_n),
        .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_cmd(cmd), .sd_in(sd_in),
        .sd_out(sd_out), .sd_oe(sd_oe), .endian_strap(strap),
        .tx_cfg_flow(flow), .tx_cfg_pad(pad), .tx_cfg_crc(crc),
        .tx_enable(en), .tx_csum_en(csum), .tx_frame_pending(pend),
        .tx_head_addr(head), .tx_rd_addr(traddr), .tx_rd_data(trd),
        .tx_done(tdone), .tx_done_bytes(tbytes), .tx_done_notify(tnote),
        .rx_frame_avail(ravail), .rx_status(rstat), .rx_byte_count(rcnt),
        .rx_word(rword), .rx_word_take(take), .rx_frame_taken(taken),
        .irq(irq));
    pq_host_model host_u (.ref_clk(ref_clk), .sd_out(sd_out),
        .bus_cs_n(cs_n), .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_cmd(cmd),
        .sd_in(sd_in));

    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cyc++;
        if (take === 1'b1)
            takes++;
        if (taken === 1'b1)
            taken_cnt++;
        if (sd_oe === 1'b1)
            oes++;
        if (cyc == 8000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic done_pulse(input logic [10:0] n, input logic note);
        @(posedge ref_clk);
        #2;
        tdone = 1'b1;
        tbytes = n;
        tnote = note;
        @(posedge ref_clk);
        #2;
        tdone = 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic test_ctl;
        oes = 0;
        host_u.rd(OFF_TXFREE, q);
        chk("free at reset", 16'h1800, q);
        // a six-clock read strobe keeps the drivers on for six clocks
        chk("drive width", 16'h0006, 16'(oes));
        host_u.wr(OFF_TXCTL, 16'hFFFF);
        host_u.rd(OFF_TXCTL, q);
        chk("control mask", 16'h01EF, q);
        host_u.wr(OFF_TXCTL, 16'h0041);
        chk("config pins", 16'h0021, {8'h00, csum, flow, pad, crc, en});
        host_u.wr(8'hA0, 16'h5555);
        host_u.rd(8'hA0, q);
        chk("unmapped", 16'h0000, q);
        $display("control test done");
    endtask

    task automatic test_manual;
        host_u.wr(OFF_IEN, 16'h4040);
        host_u.frame(16'h8005, 11'd4);
        host_u.wr(OFF_TXQCMD, 16'h0001);
        host_u.rd(OFF_TXQCMD, q);
        chk("manual set", 16'h0001, q);
        chk("frame pending", 16'h0001, {15'h0, pend});
        @(posedge ref_clk);
        @(posedge ref_clk);
        chk("control word", 16'h8005, trd);
        host_u.wr(OFF_SPREQ, 16'h0600);
        host_u.wr(OFF_TXQCMD, 16'h0003);
        host_u.rd(OFF_TXFREE, q);
        chk("no double queue", 16'h17F8, q);
        host_u.rd(OFF_IPEND, q);
        chk("space not yet", 16'h0000, q);
        done_pulse(11'd4, 1'b1);
        host_u.rd(OFF_TXQCMD, q);
        chk("bits self clear", 16'h0000, q);
        host_u.rd(OFF_IPEND, q);
        chk("pending both", 16'h4040, q);
        chk("irq raised", 16'h0001, {15'h0, irq});
        chk("head moved", 16'h0008, {3'h0, head});
        host_u.wr(OFF_IPEND, 16'hFFFF);
        host_u.rd(OFF_IPEND, q);
        chk("pending cleared", 16'h0000, q);
        chk("irq low", 16'h0000, {15'h0, irq});
        $display("manual test done");
    endtask

    task automatic test_auto;
        host_u.wr(OFF_IEN, 16'h0000);
        host_u.wr(OFF_TXQCMD, 16'h0004);
        host_u.frame(16'h0002, 11'd3);
        host_u.frame(16'h0003, 11'd1);
        host_u.rd(OFF_TXFREE, q);
        chk("two frames", 16'h17F0, q);
        done_pulse(11'd3, 1'b1);
        chk("masked irq", 16'h0000, {15'h0, irq});
        host_u.rd(OFF_IPEND, q);
        chk("done pending", 16'h4000, q);
        host_u.wr(OFF_IEN, 16'h4000);
        chk("unmasked irq", 16'h0001, {15'h0, irq});
        done_pulse(11'd1, 1'b0);
        host_u.rd(OFF_TXFREE, q);
        chk("all freed", 16'h1800, q);
        chk("none pending", 16'h0000, {15'h0, pend});
        host_u.wr(OFF_IPEND, 16'hFFFF);
        $display("auto test done");
    endtask

    task automatic test_rx;
        host_u.wr(OFF_RXQCMD, 16'h0008);
        host_u.rd(OFF_QDATA, q);
        chk("status swapped", 16'h3412, q);
        host_u.rd(OFF_QDATA, q);
        chk("count swapped", 16'h0600, q);
        for (int i = 0; i < 3; i++)
        begin
            host_u.rd(OFF_QDATA, q);
            chk("rx data", 16'hBEEF, q);
        end
        chk("words taken", 16'h0003, 16'(takes));
        chk("frame taken", 16'h0001, 16'(taken_cnt));
        // three 8-byte extents queued so far put the tail at word 12
        host_u.wr(OFF_TXPTR, 16'h4000);
        host_u.wr(OFF_QDATA, 16'h1234);
        #2;
        traddr = 12'h00C;
        repeat (2) @(posedge ref_clk);
        chk("tx data swapped", 16'h3412, trd);
        $display("receive test done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        strap = 1'b0;
        tdone = 1'b0;
        tnote = 1'b0;
        tbytes = 11'h000;
        traddr = 12'h000;
        ravail = 1'b0;
        rstat = 16'h1234;
        rcnt = 12'h006;
        rword = 16'hBEEF;
        repeat (16) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        test_ctl();
        test_manual();
        test_auto();
        #2;
        strap = 1'b1;
        ravail = 1'b1;
        test_rx();
        finish_test();
    end
endmodule // tb
`default_nettype wire
